// ### monitor_alarm_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "monitor_alarm_defines.svh"

module monitor_alarm_status_regs (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire monitor_alarm_pkg::reg_access_type i_reg,
  input wire monitor_alarm_pkg::conversion_type i_conversion,
  output logic [7:0] o_reg_rdata,
  output logic [1:0] o_page_select,
  output logic o_combined_interrupt_status,
  output logic o_buffer_output_first_o,
  output logic o_buffer_output_first_oe
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [7:0] limit_mem [0:15];
  logic [15:0] measure_q [0:3];
  logic [7:0] int_enable_q;
  logic [1:0] page_q;
  logic [7:0] rdata_q;
  logic int_q;
  logic pin_oe_q;
  logic pin_o_q;
  logic [3:0] flag_bits;
  logic [3:0] update_clear;
  logic [3:0] high_alarm;
  logic [3:0] low_alarm;
  logic [7:0] alarm_byte;
  logic [7:0] update_byte;
  monitor_alarm_pkg::limit_pair_type limits [0:3];
  logic int_d;
  logic [7:0] rdata_d;

  function automatic logic in_limit_space(input logic [7:0] addr);
    return (addr <= `LIMIT_TOP_OFFSET) && !addr[2];
  endfunction

  function automatic logic [3:0] limit_index(input logic [7:0] addr);
    return {addr[4:3], addr[1:0]};
  endfunction

  wire logic upd_write = i_reg.write && (i_reg.addr == `CONV_UPDATE_OFFSET);

  // ****************************************************************
  // Measurement capture and update flags
  // ****************************************************************
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      for (int c = 0; c < 4; c++) begin
        measure_q[c] <= 16'h0000;
      end
    end else begin
      for (int c = 0; c < 4; c++) begin
        if (i_conversion.done[c]) begin
          measure_q[c] <= i_conversion.value[c];
        end
      end
    end
  end

  for (genvar c = 0; c < 4; c++) begin : g_chan
    assign update_clear[c] = upd_write && !i_reg.wdata[`UPDATE_TOP_BIT - c];
    update_flag u_flag (
      .i_clock(i_clock),
      .i_resetn(i_resetn),
      .i_set(i_conversion.done[c]),
      .i_clear(update_clear[c]),
      .o_flag(flag_bits[c])
    );
    limit_checker #(.WIDTH(16)) u_check (
      .i_clock(i_clock),
      .i_resetn(i_resetn),
      .i_value(measure_q[c]),
      .i_high(limits[c].high),
      .i_low(limits[c].low),
      .o_high_alarm(high_alarm[c]),
      .o_low_alarm(low_alarm[c])
    );
    assign alarm_byte[`ALARM_TOP_BIT - 2 * c] = high_alarm[c];
    assign alarm_byte[`ALARM_TOP_BIT - 2 * c - 1] = low_alarm[c];
    assign update_byte[`UPDATE_TOP_BIT - c] = flag_bits[c];
  end
  assign update_byte[3:0] = 4'h0;

  // ****************************************************************
  // Limit storage, most significant byte at the lower address
  // ****************************************************************
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      limits[c].high = {limit_mem[4 * c], limit_mem[4 * c + 1]};
      limits[c].low = {limit_mem[4 * c + 2], limit_mem[4 * c + 3]};
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      for (int i = 0; i < 16; i++) begin
        limit_mem[i] <= `LIMIT_RESET;
      end
    end else if (i_reg.write && in_limit_space(i_reg.addr)) begin
      limit_mem[limit_index(i_reg.addr)] <= i_reg.wdata;
    end
  end

  // ****************************************************************
  // Page select and interrupt enable
  // ****************************************************************
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      page_q <= `PAGE_RESET;
    end else if (i_reg.write && (i_reg.addr == `PAGE_SELECT_OFFSET)) begin
      page_q <= i_reg.wdata[1:0];
    end
  end

  // The enable byte lives in the upper memory of table 01 only.
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      int_enable_q <= `INT_ENABLE_RESET;
    end else if (i_reg.write && (i_reg.addr == `INT_ENABLE_OFFSET) &&
                 (page_q == `PAGE_TABLE_01)) begin
      int_enable_q <= i_reg.wdata;
    end
  end

  // ****************************************************************
  // Combined interrupt and buffer pin
  // ****************************************************************
  always_comb begin
    int_d = 1'b0;
    for (int c = 0; c < 4; c++) begin
      int_d = int_d | ((high_alarm[c] | low_alarm[c]) &
                       int_enable_q[`UPDATE_TOP_BIT - c]);
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      int_q <= 1'b0;
    end else begin
      int_q <= int_d;
    end
  end

  // The pin is pulled low while quiet and released high on an interrupt.
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      pin_oe_q <= 1'b1;
      pin_o_q <= 1'b0;
    end else begin
      pin_oe_q <= !int_q;
      pin_o_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  always_comb begin
    rdata_d = 8'h00;
    if (in_limit_space(i_reg.addr)) begin
      rdata_d = limit_mem[limit_index(i_reg.addr)];
    end else if ((i_reg.addr >= `MEASURE_BASE_OFFSET) &&
                 (i_reg.addr <= `MEASURE_TOP_OFFSET)) begin
      rdata_d = i_reg.addr[0] ? measure_q[i_reg.addr[2:1]][7:0]
                              : measure_q[i_reg.addr[2:1]][15:8];
    end else begin
      case (i_reg.addr)
        `CONV_UPDATE_OFFSET: rdata_d = update_byte;
        `ALARM_FLAGS_OFFSET: rdata_d = alarm_byte;
        `INT_STATUS_OFFSET: rdata_d = {7'h00, int_q};
        `PAGE_SELECT_OFFSET: rdata_d = {6'h00, page_q};
        `INT_ENABLE_OFFSET: begin
          rdata_d = (page_q == `PAGE_TABLE_01) ? int_enable_q : 8'h00;
        end
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      rdata_q <= 8'h00;
    end else if (i_reg.read) begin
      rdata_q <= rdata_d;
    end
  end

  assign o_reg_rdata = rdata_q;
  assign o_page_select = page_q;
  assign o_combined_interrupt_status = int_q;
  assign o_buffer_output_first_o = pin_o_q;
  assign o_buffer_output_first_oe = pin_oe_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_resetn);

  sequence clear_supply_s;
    upd_write && !i_reg.wdata[6] && !i_conversion.done[1];
  endsequence

  sequence quiet_supply_s;
    !i_conversion.done[1] [*2];
  endsequence

  sequence gated_enable_write_s;
    i_reg.write && (i_reg.addr == `INT_ENABLE_OFFSET) &&
      (page_q != `PAGE_TABLE_01);
  endsequence

  chk_supply_flag_set: assert property (
    i_conversion.done[1] |=> update_byte[6])
    else $error("supply update flag not set");
  chk_aux_a_flag: assert property (
    i_conversion.done[2] |=> update_byte[5])
    else $error("aux a update flag not set");
  chk_aux_b_flag: assert property (
    i_conversion.done[3] |=> update_byte[4])
    else $error("aux b update flag not set");
  chk_temp_flag_set: assert property (
    i_conversion.done[0] && upd_write |=> update_byte[7])
    else $error("temperature update flag lost to clear");
  chk_clear_holds_low: assert property (
    clear_supply_s ##1 quiet_supply_s |-> !update_byte[6] [*2])
    else $error("supply update flag returned without conversion");
  chk_reserved_bits_zero: assert property (
    i_reg.read && (i_reg.addr == `CONV_UPDATE_OFFSET) |=>
      o_reg_rdata[3:0] == 4'h0)
    else $error("reserved update bits not zero");
  chk_temp_high_alarm: assert property (
    measure_q[0] > limits[0].high |=> alarm_byte[7])
    else $error("temperature high alarm missing");
  chk_supply_low_alarm: assert property (
    limits[1].low > measure_q[1] |=> alarm_byte[4])
    else $error("supply low alarm missing");
  chk_aux_a_alarm: assert property (
    ##1 alarm_byte[3] == $past(measure_q[2] > limits[2].high))
    else $error("aux a high alarm wrong");
  chk_aux_b_alarm: assert property (
    ##1 alarm_byte[0] == $past(limits[3].low > measure_q[3]))
    else $error("aux b low alarm wrong");
  chk_interrupt_mask: assert property (
    ##1 int_q == $past(|({high_alarm | low_alarm} &
                        {int_enable_q[4], int_enable_q[5],
                         int_enable_q[6], int_enable_q[7]})))
    else $error("combined interrupt not masked alarms");
  chk_enable_zero_quiet: assert property (
    int_enable_q == 8'h00 [*2] |-> !int_q)
    else $error("combined interrupt set with enables off");
  chk_page_write: assert property (
    i_reg.write && (i_reg.addr == `PAGE_SELECT_OFFSET) |=>
      page_q == $past(i_reg.wdata[1:0]))
    else $error("page select not stored");
  chk_pin_follows: assert property (
    int_q |=> !o_buffer_output_first_oe)
    else $error("buffer output not released on interrupt");
  chk_supply_capture: assert property (
    i_conversion.done[1] |=> measure_q[1] == $past(i_conversion.value[1]))
    else $error("supply result not stored");
  chk_supply_flag_holds: assert property (
    update_byte[6] && !(upd_write && !i_reg.wdata[6]) |=> update_byte[6])
    else $error("supply update flag dropped without clear");
  chk_aux_a_clear: assert property (
    upd_write && !i_reg.wdata[5] && !i_conversion.done[2] |=>
      !update_byte[5])
    else $error("aux a update flag not cleared");
  chk_enable_gated: assert property (
    gated_enable_write_s |=> $stable(int_enable_q))
    else $error("enable byte written outside its table");
  chk_status_read: assert property (
    i_reg.read && (i_reg.addr == `INT_STATUS_OFFSET) |=>
      o_reg_rdata == {7'h00, $past(int_q)})
    else $error("combined status read wrong");

endmodule // monitor_alarm_status_regs

`default_nettype wire

// ### monitor_alarm_defines.svh
`ifndef MONITOR_ALARM_DEFINES_SVH
`define MONITOR_ALARM_DEFINES_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define LIMIT_TOP_OFFSET 8'h1F
`define MEASURE_BASE_OFFSET 8'h60
`define MEASURE_TOP_OFFSET 8'h67
`define CONV_UPDATE_OFFSET 8'h6F
`define ALARM_FLAGS_OFFSET 8'h70
`define INT_STATUS_OFFSET 8'h71
`define PAGE_SELECT_OFFSET 8'h7F
`define INT_ENABLE_OFFSET 8'h88

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define UPDATE_TOP_BIT 7
`define ALARM_TOP_BIT 7
`define INT_STATUS_BIT 0
`define PAGE_TABLE_01 2'h1
`define PAGE_RESET 2'h0
`define INT_ENABLE_RESET 8'hF0
`define LIMIT_RESET 8'h00

`endif

// ### monitor_alarm_pkg.sv
`default_nettype none

package monitor_alarm_pkg;

  typedef struct packed {
    logic [15:0] high;
    logic [15:0] low;
  } limit_pair_type;

  typedef struct packed {
    logic [3:0] done;
    logic [3:0][15:0] value;
  } conversion_type;

  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_access_type;

endpackage

`default_nettype wire

// ### update_flag.sv
`timescale 1ns/1ps
`default_nettype none

module update_flag (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_set,
  input wire logic i_clear,
  output logic o_flag
);

  logic flag_q;

  // A fresh result arriving with a host clear keeps the flag set.
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      flag_q <= 1'b0;
    end else if (i_set) begin
      flag_q <= 1'b1;
    end else if (i_clear) begin
      flag_q <= 1'b0;
    end
  end

  assign o_flag = flag_q;

endmodule // update_flag

`default_nettype wire

// ### limit_checker.sv
`timescale 1ns/1ps
`default_nettype none

module limit_checker #(
  parameter int WIDTH = 16
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic [WIDTH-1:0] i_value,
  input wire logic [WIDTH-1:0] i_high,
  input wire logic [WIDTH-1:0] i_low,
  output logic o_high_alarm,
  output logic o_low_alarm
);

  logic high_q;
  logic low_q;

  function automatic logic beyond(input logic [WIDTH-1:0] a,
                                  input logic [WIDTH-1:0] b);
    return a > b;
  endfunction

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      high_q <= 1'b0;
      low_q <= 1'b0;
    end else begin
      high_q <= beyond(i_value, i_high);
      low_q <= beyond(i_low, i_value);
    end
  end

  assign o_high_alarm = high_q;
  assign o_low_alarm = low_q;

endmodule // limit_checker

`default_nettype wire

// ### host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Host on the register bus
// ****************************************
module host_model (
  input wire logic i_clock,
  input wire logic [7:0] i_rdata,
  output var monitor_alarm_pkg::reg_access_type o_reg
);
  initial o_reg = '0;

  // Released lines show the inverted address, and inverted data after a write, so stale data never looks valid.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    o_reg <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
    @(posedge i_clock);
    o_reg <= '{write: 1'b0, read: 1'b0, addr: ~a, wdata: ~d};
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clock);
    o_reg <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_clock);
    o_reg <= '{write: 1'b0, read: 1'b0, addr: ~a, wdata: 8'hA5};
    #1;
    d = i_rdata;
  endtask
endmodule // host_model

`default_nettype wire

// ### monitor_alarm_status_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none

module monitor_alarm_status_regs_bench;
  logic i_clock;
  logic i_resetn;
  monitor_alarm_pkg::reg_access_type reg_bus;
  monitor_alarm_pkg::conversion_type conv;
  logic [7:0] rdata;
  logic [1:0] page;
  logic intr;
  logic pin_o;
  logic pin_oe;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [15:0] hi [4];
  logic [15:0] lo [4];
  logic [15:0] meas [4];
  logic [7:0] upd;
  logic [7:0] en;

  monitor_alarm_status_regs dut (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_reg(reg_bus),
    .i_conversion(conv),
    .o_reg_rdata(rdata),
    .o_page_select(page),
    .o_combined_interrupt_status(intr),
    .o_buffer_output_first_o(pin_o),
    .o_buffer_output_first_oe(pin_oe)
  );

  host_model host (.i_clock(i_clock), .i_rdata(rdata), .o_reg(reg_bus));

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  // The tests need about 1400 cycles; the ceiling leaves ample margin.
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      $display("[ERR] %0t run did not finish in time", $time);
      end_sim();
    end
  end

  // ****************************************
  // Expectations and helpers
  // ****************************************
  function automatic logic [7:0] alarms();
    logic [7:0] a;
    a = 8'h00;
    for (int c = 0; c < 4; c++) begin
      a[7-2*c] = meas[c] > hi[c];
      a[6-2*c] = meas[c] < lo[c];
    end
    return a;
  endfunction

  function automatic logic combined();
    logic [7:0] a;
    logic r;
    a = alarms();
    r = 1'b0;
    for (int c = 0; c < 4; c++) begin
      r = r | ((a[7-2*c] | a[6-2*c]) & en[7-c]);
    end
    return r;
  endfunction

  task automatic reset_model();
    upd = 8'h00;
    en = 8'hF0;
    for (int c = 0; c < 4; c++) begin
      hi[c] = 16'h0000;
      lo[c] = 16'h0000;
      meas[c] = 16'h0000;
    end
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk(d, e);
  endtask

  task automatic pins_chk();
    chk({5'h00, pin_o, pin_oe, intr}, {6'h00, ~combined(), combined()});
  endtask

  task automatic convert(input int c, input logic [15:0] v);
    @(posedge i_clock);
    conv.value[c] <= v;
    conv.done <= 4'(1 << c);
    @(posedge i_clock);
    conv.done <= 4'h0;
    meas[c] = v;
    upd[7-c] = 1'b1;
    repeat (4) @(posedge i_clock);
  endtask

  task automatic set_limits(input int c, input logic [15:0] h,
                            input logic [15:0] l);
    logic [7:0] b;
    b = 8'(8 * c);
    host.wr(b, h[15:8]);
    host.wr(b + 8'h01, h[7:0]);
    host.wr(b + 8'h02, l[15:8]);
    host.wr(b + 8'h03, l[7:0]);
    hi[c] = h;
    lo[c] = l;
  endtask

  task automatic end_sim();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [15:0] h;
    logic [15:0] l;
    logic [15:0] v;
    logic [7:0] d;
    int c;
    i_resetn = 1'b0;
    conv = '0;
    reset_model();
    void'($urandom(32'hE2BB3A68));
    repeat (6) @(posedge i_clock);
    i_resetn <= 1'b1;
    rd_chk(8'h6F, 8'h00);
    rd_chk(8'h70, 8'h00);
    pins_chk();
    for (int p = 0; p < 4; p++) begin
      d = 8'($urandom);
      d[1:0] = 2'(p);
      host.wr(8'h7F, d);
      rd_chk(8'h7F, {6'h00, 2'(p)});
      chk({6'h00, page}, {6'h00, 2'(p)});
    end
    for (int n = 0; n < 48; n++) begin
      h = 16'($urandom);
      l = 16'($urandom);
      v = 16'($urandom);
      // Equal values sit on the limit and must not raise an alarm.
      if (n < 4) v = h;
      else if (n < 8) v = l;
      set_limits(n % 4, h, l);
      convert(n % 4, v);
      c = n % 4;
      rd_chk(8'(8 * c), hi[c][15:8]);
      rd_chk(8'(8 * c + 3), lo[c][7:0]);
      rd_chk(8'(8'h60 + 2 * c), meas[c][15:8]);
      rd_chk(8'(8'h61 + 2 * c), meas[c][7:0]);
      rd_chk(8'h70, alarms());
      rd_chk(8'h6F, upd);
      pins_chk();
    end
    host.wr(8'h6F, 8'h0F);
    upd = 8'h00;
    rd_chk(8'h6F, 8'h00);
    host.wr(8'h6F, 8'hF0);
    rd_chk(8'h6F, 8'h00);
    convert(1, 16'(meas[1] + 16'h0001));
    rd_chk(8'h6F, 8'h40);
    // A fresh result landing with a clearing write keeps its flag set.
    upd = 8'h00;
    fork
      convert(0, 16'($urandom));
      host.wr(8'h6F, 8'h00);
    join
    rd_chk(8'h6F, upd);
    host.wr(8'h70, 8'hFF);
    rd_chk(8'h70, alarms());
    rd_chk(8'h04, 8'h00);
    rd_chk(8'h88, 8'h00);
    host.wr(8'h7F, 8'h01);
    rd_chk(8'h88, 8'hF0);
    for (int k = 0; k < 6; k++) begin
      d = (k == 0) ? 8'h00 : 8'($urandom);
      host.wr(8'h88, d);
      en = d;
      repeat (4) @(posedge i_clock);
      pins_chk();
      rd_chk(8'h71, {7'h00, combined()});
    end
    host.wr(8'h7F, 8'h02);
    host.wr(8'h88, ~en);
    host.wr(8'h7F, 8'h01);
    rd_chk(8'h88, en);
    @(posedge i_clock);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_resetn <= 1'b1;
    reset_model();
    rd_chk(8'h7F, 8'h00);
    rd_chk(8'h6F, 8'h00);
    rd_chk(8'h70, 8'h00);
    pins_chk();
    end_sim();
  end
endmodule // monitor_alarm_status_regs_bench

`default_nettype wire
